/* logic/gdc_pkg.sv */
package gdc_pkg;

	// --------------------------------------------------------------
	// Clock and timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;     // 25 MHz core clock
	localparam int POR_MAX_NS     = 20000;  // Longest startup interval
	// Longest time, so round down
	localparam int POR_CYCLES     = POR_MAX_NS / CLK_PERIOD_NS;
	localparam int HOLDOFF_NS     = 1000;   // Three-state hold-off, plain default
	// Least time, so round up
	localparam int HOLDOFF_CYCLES = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 16;     // Width of every delay counter

	// --------------------------------------------------------------
	// Register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_STATUS   = 8'h04;
	localparam logic [7:0]  OFF_HOLDOFF  = 8'h08;

	// Control fields
	localparam int          CTRL_EN_BIT  = 0;      // Software enable
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
	localparam logic [CNT_W-1:0] HOLDOFF_RST = CNT_W'(HOLDOFF_CYCLES);

	// Status fields
	localparam int ST_RUN_BIT   = 0;
	localparam int ST_START_BIT = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam int ST_THERM_BIT = 3;
	localparam int ST_TRI_BIT   = 4;
	localparam int ST_NCM_BIT   = 5;
	localparam int ST_DCM_BIT   = 6;
	localparam int ST_GH_BIT    = 7;
	localparam int ST_GL_BIT    = 8;

	// Driver states
	typedef enum logic [1:0] {GDC_OFF, GDC_START, GDC_RUN, GDC_FAULT} gdc_state_t;

endpackage : gdc_pkg

/* logic/gdc_timer.sv */
// Saturating delay counter; done rises after limit cycles of run
module gdc_timer
	import gdc_pkg::*;
#(
	parameter int W = CNT_W
)(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              done
);

	logic [W-1:0] count_reg;   // Elapsed cycles
	logic [W-1:0] count_next;
	logic         done_reg;    // Limit reached
	logic         done_next;

	// --------------------------------------------------------------
	// Next count
	// --------------------------------------------------------------
	always_comb
	begin
		if (!run)
			count_next = '0;                // Restart on every gap
		else if (count_reg >= limit)
			count_next = count_reg;         // Saturate, also if limit shrinks
		else
			count_next = count_reg + W'(1);
		done_next = run && (count_next >= limit);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= '0;
			done_reg  <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end

	assign done = done_reg;

endmodule // gdc_timer

/* logic/gdc_gate_drive_control.sv */
// Behaviour
// - Gates low while supply undervoltage
// - Startup delay bounded, then follow PWM
// - Start for any supply/enable ordering
// - Enable pin low forces both gates low
// - Re-enable repeats bounded startup interval
// - Open-drain pin; floating reads disabled
// - Fault pulls shared enable pin low
// - Faults: high-side short, thermal shutdown
// - Fault latched until new supply power-up
// - Three-state past hold-off: gates low
// - High gate in phase with PWM
// - Low gate inverted; low when disabled
// - Zero-cross low: off on reversed current
// - Negative current selects reduced drive
// - Leaving three-state follows new PWM
// - Negative mode: weak path only
//
// Added by the designer: the address map and the APB interface to the registers.
module gdc_gate_drive_control
	import gdc_pkg::*;
#(
	parameter int POR_LEN     = POR_CYCLES,     // Startup cycles
	parameter int HOLDOFF_LEN = HOLDOFF_CYCLES  // Default hold-off cycles
)(
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Power stage side
	input  wire logic        supply_undervoltage_ok,
	input  wire logic        pwm_high,           // PWM above high trip
	input  wire logic        pwm_tristate,       // PWM inside three-state window
	input  wire logic        zero_cross_in_n,
	input  wire logic        current_negative_in, // Negative current sensed
	input  wire logic        hs_short_in,        // High-side false turn-on
	input  wire logic        temp_monitor_over,  // Temperature monitor tripped
	input  wire logic        en_fault_in,        // Enable/fault pin level
	output logic             en_fault_out,
	output logic             en_fault_oe,
	output logic             high_gate_out,
	output logic             low_gate_out,
	output logic             low_side_drive,
	output logic             weak_low_drive,
	output logic             negative_current_mode,
	output logic             discontinuous_mode
);

	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	gdc_state_t       state_reg, state_next;     // Driver state
	logic [31:0]      ctrl_reg, ctrl_next;       // Control word
	logic [CNT_W-1:0] hold_reg, hold_next;       // Hold-off length
	logic [31:0]      prdata_reg, prdata_next;   // Read data
	logic             pready_reg, pready_next;   // Access phase answer
	logic             pslverr_reg, pslverr_next; // Unmapped address
	logic             gh_reg, gh_next;           // High gate
	logic             gl_reg, gl_next;           // Low gate
	logic             lsd_reg, lsd_next;         // Strong low path
	logic             wld_reg, wld_next;         // Weak low path
	logic             ncm_reg, ncm_next;         // Negative-current mode
	logic             zco_reg, zco_next;         // Auto low-side cut-off
	logic             oe_reg, oe_next;           // Pin pull-down
	logic             therm_reg, therm_next;     // Thermal fault seen
	logic             enable;                    // Pin and software enable
	logic             fault_now;                 // Fault condition this cycle
	logic             drive_ok;                  // Gates may follow PWM
	logic             tri_off;                   // Hold-off expired
	logic             start_done;                // Startup elapsed
	logic             tri_done;                  // Three-state timer elapsed
	logic             setup;                     // APB setup cycle
	logic             wr_acc;                    // APB write taken

	// --------------------------------------------------------------
	// Address decode for the unmapped-address error (pslverr) only
	// --------------------------------------------------------------
	function automatic logic addr_known(input logic [7:0] a);
		return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_HOLDOFF);
	endfunction

	// --------------------------------------------------------------
	// Delay counters
	// --------------------------------------------------------------
	// Startup interval; one cycle of state change is added, so limit is one short
	gdc_timer #(.W(CNT_W)) u_start (
		.clk   (clk),
		.rst   (rst),
		.run   (state_reg == GDC_START),
		.limit (CNT_W'(POR_LEN - 1)),
		.done  (start_done)
	);

	// Three-state dwell; any exit from the window restarts it
	gdc_timer #(.W(CNT_W)) u_tri (
		.clk   (clk),
		.rst   (rst),
		.run   (pwm_tristate),
		.limit (hold_reg),
		.done  (tri_done)
	);

	// --------------------------------------------------------------
	// Enable and fault qualification
	// --------------------------------------------------------------
	// A floating pin reads low through the pull-down, so it disables
	assign enable    = en_fault_in && ctrl_reg[CTRL_EN_BIT];
	assign fault_now = (hs_short_in && gl_reg) || temp_monitor_over;
	// Qualified on this cycle's inputs so gates drop one edge later
	assign drive_ok  = (state_reg == GDC_RUN) && enable && supply_undervoltage_ok
	                   && !fault_now;
	assign tri_off   = tri_done && pwm_tristate;
	assign setup     = psel && !penable;
	assign wr_acc    = psel && penable && pwrite && pready_reg;

	// --------------------------------------------------------------
	// Driver state machine
	// --------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			GDC_OFF:
				// Any ordering of supply and enable lands here first
				if (supply_undervoltage_ok && enable)
					state_next = GDC_START;
			GDC_START:
				if (!supply_undervoltage_ok || !enable)
					state_next = GDC_OFF;
				else if (start_done)
					state_next = GDC_RUN;
			GDC_RUN:
				if (!supply_undervoltage_ok)
					state_next = GDC_OFF;
				else if (fault_now)
					state_next = GDC_FAULT;
				else if (!enable)
					state_next = GDC_OFF;             // Re-enable repeats startup
			GDC_FAULT:
				// Only a supply drop clears it; enable is ignored
				if (!supply_undervoltage_ok)
					state_next = GDC_OFF;
			default:
				state_next = GDC_OFF;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= GDC_OFF;
		else
			state_reg <= state_next;
	end

	// --------------------------------------------------------------
	// Gate outputs and low-side drive strength
	// --------------------------------------------------------------
	always_comb
	begin
		// Reversal latch: set on negative current while ZCD low, cleared by PWM high
		if (!drive_ok || (pwm_high && !pwm_tristate))
			zco_next = 1'b0;
		else if (!zero_cross_in_n && current_negative_in)
			zco_next = 1'b1;
		else
			zco_next = zco_reg;
		if (!drive_ok || tri_off)
		begin
			gh_next = 1'b0;
			gl_next = 1'b0;
		end
		else if (pwm_tristate)
		begin
			// Window not yet long enough: keep the last gate state
			gh_next = gh_reg;
			gl_next = gl_reg;
		end
		else
		begin
			gh_next = pwm_high;
			gl_next = !pwm_high && !zco_next;
		end
		// Mode re-evaluated each low-side on-time
		if (!drive_ok)
			ncm_next = 1'b0;
		else if (gl_reg && current_negative_in)
			ncm_next = 1'b1;
		else if (gl_next && !gl_reg)
			ncm_next = 1'b0;
		else
			ncm_next = ncm_reg;
		// Weak path always serves; strong path joins outside negative mode
		lsd_next = gl_next && !ncm_next;
		wld_next = gl_next;
		oe_next  = (state_next == GDC_FAULT);
		if (state_next == GDC_OFF && !supply_undervoltage_ok)
			therm_next = 1'b0;
		else if (state_reg == GDC_RUN && temp_monitor_over)
			therm_next = 1'b1;
		else
			therm_next = therm_reg;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gh_reg    <= 1'b0;
			gl_reg    <= 1'b0;
			lsd_reg   <= 1'b0;
			wld_reg   <= 1'b0;
			ncm_reg   <= 1'b0;
			zco_reg   <= 1'b0;
			oe_reg    <= 1'b0;
			therm_reg <= 1'b0;
		end
		else
		begin
			gh_reg    <= gh_next;
			gl_reg    <= gl_next;
			lsd_reg   <= lsd_next;
			wld_reg   <= wld_next;
			ncm_reg   <= ncm_next;
			zco_reg   <= zco_next;
			oe_reg    <= oe_next;
			therm_reg <= therm_next;
		end
	end

	// --------------------------------------------------------------
	// APB slave: one wait-free access phase after each setup
	// --------------------------------------------------------------
	always_comb
	begin
		ctrl_next    = ctrl_reg;
		hold_next    = hold_reg;
		prdata_next  = '0;
		pready_next  = setup;                 // Answer in the access phase
		pslverr_next = setup && !addr_known(paddr);
		if (setup && !pwrite)
		begin
			case (paddr)
				OFF_CTRL:    prdata_next = ctrl_reg;
				OFF_HOLDOFF: prdata_next = 32'(hold_reg);
				OFF_STATUS:
				begin
					prdata_next[ST_RUN_BIT]   = (state_reg == GDC_RUN);
					prdata_next[ST_START_BIT] = (state_reg == GDC_START);
					prdata_next[ST_FAULT_BIT] = (state_reg == GDC_FAULT);
					prdata_next[ST_THERM_BIT] = therm_reg;
					prdata_next[ST_TRI_BIT]   = tri_off;
					prdata_next[ST_NCM_BIT]   = ncm_reg;
					prdata_next[ST_DCM_BIT]   = zco_reg;
					prdata_next[ST_GH_BIT]    = gh_reg;
					prdata_next[ST_GL_BIT]    = gl_reg;
				end
				default:     prdata_next = '0;   // Unmapped reads zero
			endcase
		end
		// Write lands only at the edge that samples pready
		if (wr_acc && paddr == OFF_CTRL)
			ctrl_next = {31'h0, pwdata[CTRL_EN_BIT]};
		if (wr_acc && paddr == OFF_HOLDOFF)
			hold_next = pwdata[CNT_W-1:0];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg    <= CTRL_RST;
			hold_reg    <= CNT_W'(HOLDOFF_LEN);
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			hold_reg    <= hold_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// --------------------------------------------------------------
	// Output wiring, all from flip-flops
	// --------------------------------------------------------------
	assign prdata                = prdata_reg;
	assign pready                = pready_reg;
	assign pslverr               = pslverr_reg;
	assign en_fault_out          = 1'b0 & oe_reg;  // Open drain only pulls low
	assign en_fault_oe           = oe_reg;
	assign high_gate_out         = gh_reg;
	assign low_gate_out          = gl_reg;
	assign low_side_drive        = lsd_reg;
	assign weak_low_drive        = wld_reg;
	assign negative_current_mode = ncm_reg;
	assign discontinuous_mode    = zco_reg;

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [CNT_W-1:0] start_age_reg;   // Cycles spent in startup
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			start_age_reg <= '0;
		else if (state_reg == GDC_START)
			start_age_reg <= start_age_reg + CNT_W'(1);
		else
			start_age_reg <= '0;
	end

	supply_undervoltage_ok_gates_off_a: assert property (!supply_undervoltage_ok |=> !high_gate_out && !low_gate_out)
		else $error("gate on under supply undervoltage");
	start_bound_a: assert property (start_age_reg <= CNT_W'(POR_LEN))
		else $error("startup exceeded its limit");
	disable_low_a: assert property (!en_fault_in |=> !high_gate_out && !low_gate_out)
		else $error("gate on while enable pin low");
	fault_pulls_a: assert property ((state_reg == GDC_RUN) && supply_undervoltage_ok && fault_now
		|=> en_fault_oe && !high_gate_out)
		else $error("fault not flagged on pin");
	fault_latched_a: assert property (en_fault_oe && supply_undervoltage_ok |=> en_fault_oe)
		else $error("fault latch released without power-up");
	tri_hold_a: assert property (pwm_tristate && tri_done |=> !high_gate_out && !low_gate_out)
		else $error("gates on after three-state hold-off");
	hs_phase_a: assert property (drive_ok && !pwm_tristate |=> high_gate_out == $past(pwm_high))
		else $error("high gate out of phase");
	ls_follow_a: assert property (drive_ok && !pwm_tristate && !pwm_high && zero_cross_in_n
		&& !zco_reg |=> low_gate_out && !high_gate_out)
		else $error("low gate not inverted from PWM");
	zc_cut_a: assert property (drive_ok && !pwm_tristate && !zero_cross_in_n
		&& current_negative_in |=> !low_gate_out)
		else $error("low gate on after current reversal");
	weak_only_a: assert property (negative_current_mode && low_gate_out
		|-> weak_low_drive && !low_side_drive)
		else $error("strong low path used in negative mode");

	run_reached_c: cover property ((state_reg == GDC_START) ##1 (state_reg == GDC_RUN));
	fault_seen_c:  cover property ($rose(en_fault_oe));
	tri_shed_c:    cover property (high_gate_out ##1 (tri_off && !high_gate_out));
	ncm_entry_c:   cover property ($rose(negative_current_mode));

endmodule // gdc_gate_drive_control

/* dv/gdc_ctrl_model.sv */
// PWM controller on the far side of the driver
module gdc_ctrl_model
	import gdc_pkg::*;
#(
	parameter int MIN_GAP = 9  // Edges between PWM level changes
)(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       supply_ok,     // Driver supply present
	input  wire logic       drive_en,      // Controller drives pin high
	input  wire logic [1:0] pwm_cmd,       // 0 low, 1 high, 2 three-state
	input  wire logic       en_fault_oe,   // Driver pulls pin low
	input  wire logic       en_fault_out,  // Driver pin value
	output logic            pwm_high,
	output logic            pwm_tristate,
	output logic            en_fault_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------
	// PWM output
	// ----------
	logic [1:0] lvl_reg, lvl_next;  // Applied PWM level
	logic [4:0] gap_reg, gap_next;  // Edges since last change

	// Next level; commands too early are deferred, not dropped
	always_comb
	begin
		lvl_next = lvl_reg;
		gap_next = (gap_reg == 5'h1F) ? gap_reg : gap_reg + 5'h01;
		if (!supply_ok)
			lvl_next = 2'h2;  // Idle window until supply is up
		else if (pwm_cmd != lvl_reg && gap_reg >= 5'(MIN_GAP - 1))
		begin
			lvl_next = pwm_cmd;  // Edge rate capped
			gap_next = 5'h00;
		end
	end

	// Level registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lvl_reg <= 2'h2;
			gap_reg <= 5'h00;
		end
		else
		begin
			lvl_reg <= lvl_next;
			gap_reg <= gap_next;
		end
	end

	assign pwm_high     = (lvl_reg == 2'h1);
	assign pwm_tristate = (lvl_reg == 2'h2);
	// Pull-down wins when released; driver pull-down wins over us
	assign en_fault_in  = en_fault_oe ? en_fault_out : drive_en;
endmodule // gdc_ctrl_model

/* dv/gate_drive_control_bench.sv */
module gate_drive_control_bench
	import gdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------
	// Signals
	// ----------
	localparam int POR = 8;  // Short startup to keep the run brief
	localparam int HO  = 4;  // Short hold-off
	logic        clk = 1'b0, rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_d;
	logic        pready, pslverr, pwm_high, pwm_tristate;
	logic        sup = 1'b0, drv_en = 1'b0, zc_n = 1'b1, neg = 1'b0, hs_sh = 1'b0, hot = 1'b0;
	logic [1:0]  cmd = 2'h2;  // Controller PWM command
	logic        en_fault_in, en_fault_out, en_fault_oe, high_gate_out, low_gate_out;
	logic        low_side_drive, weak_low_drive, negative_current_mode, discontinuous_mode;
	int          num_errors = 0, num_checks = 0;

	always #20 clk = ~clk;  // 25 MHz

	gdc_gate_drive_control #(.POR_LEN(POR), .HOLDOFF_LEN(HO)) gdc_gate_drive_control_inst (
		.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.supply_undervoltage_ok(sup), .pwm_high, .pwm_tristate, .zero_cross_in_n(zc_n),
		.current_negative_in(neg), .hs_short_in(hs_sh), .temp_monitor_over(hot),
		.en_fault_in, .en_fault_out, .en_fault_oe, .high_gate_out, .low_gate_out,
		.low_side_drive, .weak_low_drive, .negative_current_mode, .discontinuous_mode);

	gdc_ctrl_model gdc_ctrl_model_inst (.clk, .rst, .supply_ok(sup), .drive_en(drv_en),
		.pwm_cmd(cmd), .en_fault_oe, .en_fault_out, .pwm_high, .pwm_tristate, .en_fault_in);

	// ----------
	// Tasks
	// ----------
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Settled sampling point, away from the launching edge
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One APB transfer; answer taken at the very edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
		int i;
		i = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Values read here are those sampled by this edge
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1)
		begin
			num_errors++;  // Slave never answered
			summarize();
		end
		else
		begin
			rd_d = prdata;
			chk({31'h0, pslverr}, {31'h0, err});
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 1'b0);
		chk(rd_d & mask, exp);
	endtask

	task automatic gates(input logic h, input logic l);
		chk({30'h0, high_gate_out, low_gate_out}, {30'h0, h, l});
	endtask

	// Low drive paths and modes: strong, weak, negative, cut-off
	task automatic drv(input logic [3:0] exp);
		chk({28'h0, low_side_drive, weak_low_drive, negative_current_mode,
			discontinuous_mode}, {28'h0, exp});
	endtask

	// Fault flag, pin level and both gates
	task automatic flt(input logic [3:0] exp);
		chk({28'h0, en_fault_oe, en_fault_in, high_gate_out, low_gate_out}, {28'h0, exp});
	endtask

	// PWM command, then settle well past the controller's edge spacing
	task automatic setp(input logic [1:0] c);
		@(posedge clk);
		cmd <= c;
		cyc(12);
	endtask

	task automatic zn(input logic z, input logic n);
		@(posedge clk);
		zc_n <= z;
		neg  <= n;
		cyc(4);
	endtask

	// Startup seen in status: first in startup, then running
	task automatic boot;
		cyc(2);
		rdc(OFF_STATUS, 32'h3, 32'h2);
		cyc(POR);
		rdc(OFF_STATUS, 32'h3, 32'h1);
	endtask

	// ----------
	// Sequence
	// ----------
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Register defaults, read-only bits, unmapped word
		rdc(OFF_CTRL, 32'hFFFF_FFFF, CTRL_RST);
		rdc(OFF_HOLDOFF, 32'hFFFF_FFFF, 32'(HO));
		rdc(OFF_STATUS, 32'hFFFF_FFFF, 32'h10);
		apb(1'b0, 8'h0C, 32'h0, 1'b1);
		chk(rd_d, 32'h0);
		apb(1'b1, OFF_CTRL, 32'hFFFF_FFFE, 1'b0);
		rdc(OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h1, 1'b0);
		$display("test registers done");
		// Supply first, pin released: stays off
		@(posedge clk);
		sup <= 1'b1;
		setp(2'h1);
		gates(1'b0, 1'b0);
		@(posedge clk);
		cmd    <= 2'h2;  // Idle window during startup
		drv_en <= 1'b1;
		boot();
		setp(2'h1);
		gates(1'b1, 1'b0);
		setp(2'h0);
		gates(1'b0, 1'b1);
		drv(4'b1100);
		zn(1'b0, 1'b0);
		gates(1'b0, 1'b1);
		zn(1'b0, 1'b1);
		gates(1'b0, 1'b0);
		chk({31'h0, discontinuous_mode}, 32'h1);
		setp(2'h1);
		gates(1'b1, 1'b0);
		zn(1'b1, 1'b0);
		setp(2'h0);
		drv(4'b1100);
		zn(1'b1, 1'b1);
		gates(1'b0, 1'b1);
		drv(4'b0110);
		zn(1'b1, 1'b0);
		$display("test truth table done");
		// Three-state: gates hold, then both low, then follow
		setp(2'h1);
		@(posedge clk);
		cmd <= 2'h2;
		cyc(3);
		gates(1'b1, 1'b0);
		cyc(7);
		gates(1'b0, 1'b0);
		setp(2'h0);
		gates(1'b0, 1'b1);
		apb(1'b1, OFF_HOLDOFF, 32'hA, 1'b0);
		setp(2'h1);
		@(posedge clk);
		cmd <= 2'h2;
		cyc(8);
		gates(1'b1, 1'b0);
		cyc(9);
		gates(1'b0, 1'b0);
		setp(2'h1);
		gates(1'b1, 1'b0);
		$display("test three-state done");
		// Pin released, then re-enabled
		@(posedge clk);
		drv_en <= 1'b0;
		cyc(3);
		gates(1'b0, 1'b0);
		setp(2'h0);
		gates(1'b0, 1'b0);
		@(posedge clk);
		drv_en <= 1'b1;
		boot();
		gates(1'b0, 1'b1);
		$display("test re-enable done");
		// Short while low gate on: latched until supply cycles
		@(posedge clk);
		hs_sh <= 1'b1;
		@(posedge clk);
		hs_sh <= 1'b0;
		cyc(3);
		flt(4'b1000);
		rdc(OFF_STATUS, 32'h4, 32'h4);
		@(posedge clk);
		drv_en <= 1'b0;
		cyc(3);
		@(posedge clk);
		drv_en <= 1'b1;
		cyc(POR + 4);
		setp(2'h1);
		flt(4'b1000);
		@(posedge clk);
		sup <= 1'b0;
		cyc(3);
		flt(4'b0100);
		rdc(OFF_STATUS, 32'h7, 32'h0);
		@(posedge clk);
		sup <= 1'b1;
		boot();
		setp(2'h1);
		gates(1'b1, 1'b0);
		// Thermal trip in running state
		@(posedge clk);
		hot <= 1'b1;
		cyc(3);
		flt(4'b1000);
		rdc(OFF_STATUS, 32'hC, 32'hC);
		@(posedge clk);
		hot    <= 1'b0;
		sup    <= 1'b0;
		drv_en <= 1'b0;
		cyc(3);
		@(posedge clk);
		sup    <= 1'b1;
		drv_en <= 1'b1;
		boot();
		setp(2'h1);
		gates(1'b1, 1'b0);
		$display("test faults done");
		summarize();
	end
endmodule // gate_drive_control_bench
